// *** rtl/board_ctl.sv ***
// board control lines: converter reset, mute, select, power-good, divider
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "board_ctl_regs.svh"

module board_ctl
   import board_ctl_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // board pins in
   input wire logic CONV_IRQ_B,
   input wire logic TEMP_ALARM_PIN,
   // board pins out
   output logic CONV_RST_B,
   output logic CONV_MUTE,
   output logic SPI_SEL,
   output logic PWR_OK,
   output logic [2:0] EXT_DIV,
   // interrupt
   output logic IRQ
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   state_t st_reg;
   state_t st_next;
   bus_req_t req;
   logic [1:0] sense;
   logic [1:0] fall;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   function automatic logic hit(input bus_req_t r, input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      // pins pass two flops before use
      st_next.irq_s1 = {TEMP_ALARM_PIN, CONV_IRQ_B};
      st_next.irq_s2 = st_reg.irq_s1;
      sense = st_reg.irq_s2;
      st_next.sense_prev = sense;
      // both pins are active low: a falling edge is a new event
      fall = st_reg.sense_prev & ~sense;
      st_next.rdata = 32'h0000_0000;
      if (req.wr) begin
         if (hit(req, `CTL_SET_OFS)) begin
            if (req.wdata[`CTL_RESET_BIT]) begin
               st_next.ctl.conv_rst_n = 1'b0;
            end
            if (req.wdata[`CTL_MUTE_BIT]) begin
               st_next.ctl.mute = 1'b1;
            end
            if (req.wdata[`CTL_SEL_BIT]) begin
               st_next.ctl.sel = 1'b1;
            end
            if (req.wdata[`CTL_POK_BIT]) begin
               st_next.ctl.pok = 1'b1;
            end
         end
         if (hit(req, `CTL_CLR_OFS)) begin
            if (req.wdata[`CTL_RESET_BIT]) begin
               st_next.ctl.conv_rst_n = 1'b1;
            end
            if (req.wdata[`CTL_MUTE_BIT]) begin
               st_next.ctl.mute = 1'b0;
            end
            if (req.wdata[`CTL_SEL_BIT]) begin
               st_next.ctl.sel = 1'b0;
            end
            if (req.wdata[`CTL_POK_BIT]) begin
               st_next.ctl.pok = 1'b0;
            end
         end
         if (hit(req, `DIV_OFS)) begin
            st_next.div = req.wdata[2:0];
         end
         if (hit(req, `IRQ_MASK_OFS)) begin
            st_next.mask = req.wdata[1:0];
         end
         // write one to clear
         if (hit(req, `IRQ_STAT_OFS)) begin
            st_next.stat = st_reg.stat & ~req.wdata[1:0];
         end
      end
      // new events win over a same-cycle clear
      st_next.stat = st_next.stat | fall;
      if (req.rd) begin
         unique case (req.addr)
            `CTL_SET_OFS, `CTL_CLR_OFS, `CTL_STATE_OFS: begin
               st_next.rdata = {28'h000_0000, st_reg.ctl.pok, st_reg.ctl.sel,
                  st_reg.ctl.mute, ~st_reg.ctl.conv_rst_n};
            end
            `DIV_OFS: begin
               st_next.rdata = {29'h0000_0000, st_reg.div};
            end
            `SENSE_OFS: begin
               st_next.rdata = {30'h0000_0000, sense};
            end
            `IRQ_STAT_OFS: begin
               st_next.rdata = {30'h0000_0000, st_reg.stat};
            end
            `IRQ_MASK_OFS: begin
               st_next.rdata = {30'h0000_0000, st_reg.mask};
            end
            default: begin
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end
      st_next.irq = |(st_next.stat & st_next.mask);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_reg <= '0;
         st_reg.ctl <= `CTL_RESET_VAL;
         st_reg.div <= `DIV_RESET_VAL;
         st_reg.mask <= `MASK_RESET_VAL;
         st_reg.irq_s1 <= 2'h3;
         st_reg.irq_s2 <= 2'h3;
         st_reg.sense_prev <= 2'h3;
      end else begin
         st_reg <= st_next;
      end
   end

   assign RDATA = st_reg.rdata;
   assign CONV_RST_B = st_reg.ctl.conv_rst_n;
   assign CONV_MUTE = st_reg.ctl.mute;
   assign SPI_SEL = st_reg.ctl.sel;
   assign PWR_OK = st_reg.ctl.pok;
   assign EXT_DIV = st_reg.div;
   assign IRQ = st_reg.irq;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // set asserts reset
   AST_RST_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_SET_OFS && WDATA[0]) |=> !CONV_RST_B)
      else $error("converter reset not driven low on set");

   AST_RST_CLR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_CLR_OFS && WDATA[0]) |=> CONV_RST_B)
      else $error("converter reset not released on clear");

   AST_RST_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && (ADDR == `CTL_SET_OFS || ADDR == `CTL_CLR_OFS))
      |=> $stable(CONV_RST_B))
      else $error("converter reset moved without command");

   AST_MUTE_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_SET_OFS && WDATA[1]) |=> CONV_MUTE)
      else $error("mute not set");

   AST_MUTE_CLR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_CLR_OFS && WDATA[1]) |=> !CONV_MUTE)
      else $error("mute not cleared");

   AST_MUTE_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && (ADDR == `CTL_SET_OFS || ADDR == `CTL_CLR_OFS))
      |=> $stable(CONV_MUTE))
      else $error("mute moved without command");

   AST_IRQ_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == `SENSE_OFS) |=> RDATA[0] == $past(st_reg.irq_s2[0]))
      else $error("interrupt level read wrong");

   AST_IRQ_EVENT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      $fell(st_reg.irq_s2[0]) |=> st_reg.stat[0])
      else $error("interrupt edge not recorded");

   AST_SENSE_HIGH: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == `SENSE_OFS) |=> RDATA[31:2] == 30'h0000_0000)
      else $error("sense read upper bits set");

   AST_ALARM_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == `SENSE_OFS) |=> RDATA[1] == $past(st_reg.irq_s2[1]))
      else $error("alarm level read wrong");

   AST_ALARM_EVENT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      $fell(st_reg.irq_s2[1]) |=> st_reg.stat[1])
      else $error("alarm edge not recorded");

   AST_SEL_ONLY: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_SET_OFS && WDATA[3:0] == 4'h4)
      |=> SPI_SEL && $stable(CONV_MUTE) && $stable(PWR_OK) && $stable(CONV_RST_B))
      else $error("select set disturbed other lines");

   AST_MUTE_ONLY: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_SET_OFS && WDATA[3:0] == 4'h2)
      |=> CONV_MUTE && $stable(SPI_SEL) && $stable(PWR_OK) && $stable(CONV_RST_B))
      else $error("mute set disturbed other lines");

   AST_CLR_ONLY: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_CLR_OFS && WDATA[3:0] == 4'h8)
      |=> !PWR_OK && $stable(SPI_SEL) && $stable(CONV_MUTE) && $stable(CONV_RST_B))
      else $error("power-good clear disturbed other lines");

   AST_SEL_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_SET_OFS && WDATA[2]) |=> SPI_SEL)
      else $error("select not set");

   AST_SEL_CLR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_CLR_OFS && WDATA[2]) |=> !SPI_SEL)
      else $error("select not cleared");

   AST_SEL_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && (ADDR == `CTL_SET_OFS || ADDR == `CTL_CLR_OFS))
      |=> $stable(SPI_SEL))
      else $error("select moved without command");

   AST_POK_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_SET_OFS && WDATA[3]) |=> PWR_OK)
      else $error("power-good not set");

   AST_POK_CLR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `CTL_CLR_OFS && WDATA[3]) |=> !PWR_OK)
      else $error("power-good not cleared");

   AST_POK_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && (ADDR == `CTL_SET_OFS || ADDR == `CTL_CLR_OFS))
      |=> $stable(PWR_OK))
      else $error("power-good moved without command");

   AST_READ_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && !WR) |=> $stable({CONV_RST_B, CONV_MUTE, SPI_SEL, PWR_OK, EXT_DIV}))
      else $error("read changed a control");

   AST_STATE_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == `CTL_STATE_OFS) |=> RDATA == {28'h000_0000, $past(PWR_OK),
      $past(SPI_SEL), $past(CONV_MUTE), !$past(CONV_RST_B)})
      else $error("control state read wrong");

   AST_SET_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == `CTL_SET_OFS) |=> RDATA == {28'h000_0000, $past(PWR_OK),
      $past(SPI_SEL), $past(CONV_MUTE), !$past(CONV_RST_B)})
      else $error("set place read wrong");

   AST_CLR_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == `CTL_CLR_OFS) |=> RDATA == {28'h000_0000, $past(PWR_OK),
      $past(SPI_SEL), $past(CONV_MUTE), !$past(CONV_RST_B)})
      else $error("clear place read wrong");

   AST_RD_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !RD |=> RDATA == 32'h0000_0000)
      else $error("read data outside read cycle");

   AST_DIV_WR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (WR && ADDR == `DIV_OFS) |=> EXT_DIV == $past(WDATA[2:0]))
      else $error("divider not stored");

   AST_DIV_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && ADDR == `DIV_OFS) |=> $stable(EXT_DIV))
      else $error("divider moved without write");

   AST_DIV_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RD && ADDR == `DIV_OFS) |=> RDATA == {29'h0000_0000, $past(EXT_DIV)})
      else $error("divider read wrong");

   AST_IRQ_OUT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      IRQ == |(st_reg.stat & st_reg.mask))
      else $error("interrupt output mismatch");

   AST_RST_HOLD: assert property (@(posedge SYS_CLK)
      !RST_B |-> !CONV_RST_B && !CONV_MUTE && !SPI_SEL && EXT_DIV == 3'h0)
      else $error("control defaults wrong in reset");

   AST_IRQ_RESET: assert property (@(posedge SYS_CLK)
      !RST_B |-> !IRQ && RDATA == 32'h0000_0000)
      else $error("interrupt or read data active in reset");

   // mask only moves on write
   AST_MASK_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      !(WR && ADDR == `IRQ_MASK_OFS) |=> $stable(st_reg.mask))
      else $error("mask moved without write");

endmodule

// *** rtl/board_ctl_regs.svh ***
// register offsets, field positions and reset values of the board control lines
`ifndef BOARD_CTL_REGS_SVH
`define BOARD_CTL_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CTL_SET_OFS 8'h00
`define CTL_CLR_OFS 8'h04
`define CTL_STATE_OFS 8'h08
`define DIV_OFS 8'h0C
`define SENSE_OFS 8'h10
`define IRQ_STAT_OFS 8'h14
`define IRQ_MASK_OFS 8'h18

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTL_RESET_BIT 0
`define CTL_MUTE_BIT 1
`define CTL_SEL_BIT 2
`define CTL_POK_BIT 3

// ----------------------------------------
// sense and event field positions
// ----------------------------------------
`define SENSE_IRQ_BIT 0
`define SENSE_ALARM_BIT 1
`define EV_IRQ_FALL_BIT 0
`define EV_ALARM_FALL_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTL_RESET_VAL 4'h0
`define DIV_RESET_VAL 3'h0
`define MASK_RESET_VAL 2'h0

`endif

// *** rtl/board_ctl_pkg.sv ***
// types shared by the board control lines
package board_ctl_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic pok;
      logic sel;
      logic mute;
      logic conv_rst_n;
   } ctl_t;

   typedef struct packed {
      ctl_t ctl;
      logic [2:0] div;
      logic [1:0] irq_s1;
      logic [1:0] irq_s2;
      logic [1:0] sense_prev;
      logic [1:0] stat;
      logic [1:0] mask;
      logic irq;
      logic [31:0] rdata;
   } state_t;

endpackage

// *** verification/board_pin_model.sv ***
// converter interrupt pin and temperature alarm pin model
`timescale 1ns/10ps
module board_pin_model (
   // clock from the bench, converter reset from the block, commands from the bench
   input wire logic sys_clk,
   input wire logic conv_rst_b,
   input wire logic want_irq,
   input wire logic want_alarm,
   // pins back to the block, pulled up when idle
   output logic conv_irq_b,
   output logic temp_alarm_pin
);
   initial begin
      conv_irq_b = 1'b1;
      temp_alarm_pin = 1'b1;
   end
   // interrupt low only out of reset
   always @(posedge sys_clk) begin
      conv_irq_b <= ~(want_irq & conv_rst_b);
      temp_alarm_pin <= ~want_alarm;
   end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the board control lines
`timescale 1ns/10ps
`include "board_ctl_regs.svh"
module tb_top;
   logic SYS_CLK = 1'b0;
   logic RST_B;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0000_0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic want_irq = 1'b0;
   logic want_alarm = 1'b0;
   logic [31:0] RDATA;
   logic irq_b, alarm, CONV_RST_B, CONV_MUTE, SPI_SEL, PWR_OK, IRQ;
   logic [2:0] EXT_DIV;
   logic [31:0] got;
   logic [3:0] st;
   int bad_count = 0;
   int compares = 0;

   board_ctl board_ctl_inst (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CONV_IRQ_B(irq_b),
      .TEMP_ALARM_PIN(alarm), .CONV_RST_B(CONV_RST_B),
      .CONV_MUTE(CONV_MUTE), .SPI_SEL(SPI_SEL), .PWR_OK(PWR_OK),
      .EXT_DIV(EXT_DIV), .IRQ(IRQ));
   board_pin_model board_pin_model_inst (.sys_clk(SYS_CLK),
      .conv_rst_b(CONV_RST_B), .want_irq(want_irq), .want_alarm(want_alarm),
      .conv_irq_b(irq_b), .temp_alarm_pin(alarm));

   // ----------------------------------------
   // bus tasks and checks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask
   function automatic logic [31:0] pins();
      return {25'h000_0000, EXT_DIV, PWR_OK, SPI_SEL, CONV_MUTE, CONV_RST_B};
   endfunction
   function automatic logic [31:0] pexp(input logic [3:0] s,
                                        input logic [2:0] d);
      return {25'h000_0000, d, s[3:1], ~s[0]};
   endfunction
   task automatic report_and_stop;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------
   // clock, watchdog and sequence
   // ----------------------------------------
   initial begin
      forever #10 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      #1_000_000;
      bad_count++;
      $display("MISMATCH watchdog expected done seen hang");
      report_and_stop();
   end
   initial begin
      // unknown to low gives the design a real reset edge
      RST_B <= 1'b0;
      st = 4'h1;
      repeat (20) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      #1;
      chk("pins", pexp(st, 3'h0), pins());
      rd(`CTL_STATE_OFS, got);
      chk("state", {28'h000_0000, st}, got);
      for (int i = 0; i < 4; i++) begin
         wr(`CTL_SET_OFS, 32'h0000_0001 << i);
         st[i] = 1'b1;
         chk("pins", pexp(st, 3'h0), pins());
         rd(`CTL_SET_OFS, got);
         chk("state", {28'h000_0000, st}, got);
      end
      for (int i = 0; i < 4; i++) begin
         wr(`CTL_CLR_OFS, 32'h0000_0001 << i);
         st[i] = 1'b0;
         chk("pins", pexp(st, 3'h0), pins());
         rd(`CTL_CLR_OFS, got);
         rd(`CTL_STATE_OFS, got);
         chk("state", {28'h000_0000, st}, got);
      end
      for (int v = 7; v >= 0; v--) begin
         wr(`DIV_OFS, {29'h0000_0000, 3'(v)});
         chk("div", pexp(st, 3'(v)), pins());
         rd(`DIV_OFS, got);
         chk("div_rd", {29'h0000_0000, 3'(v)}, got);
      end
      // unmapped place: write ignored, read zero
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, got);
      chk("unmapped", 32'h0000_0000, got);
      chk("pins", pexp(st, 3'h0), pins());
      wr(`IRQ_MASK_OFS, 32'h0000_0003);
      wr(`IRQ_STAT_OFS, 32'h0000_0003);
      want_irq <= 1'b1;
      repeat (6) @(posedge SYS_CLK);
      rd(`SENSE_OFS, got);
      chk("sense", 32'h0000_0002, got);
      chk("irq", 32'h0000_0001, {31'h0000_0000, IRQ});
      wr(`IRQ_STAT_OFS, 32'h0000_0001);
      rd(`IRQ_STAT_OFS, got);
      chk("stat", 32'h0000_0000, got + IRQ);
      wr(`IRQ_MASK_OFS, 32'h0000_0000);
      want_alarm <= 1'b1;
      repeat (6) @(posedge SYS_CLK);
      rd(`SENSE_OFS, got);
      chk("sense", 32'h0000_0000, got);
      rd(`IRQ_STAT_OFS, got);
      chk("stat", 32'h0000_0002, got + IRQ);
      wr(`IRQ_MASK_OFS, 32'h0000_0002);
      @(posedge SYS_CLK);
      #1;
      chk("irq", 32'h0000_0001, {31'h0000_0000, IRQ});
      // mid-run reset must restore every default
      wr(`CTL_SET_OFS, 32'h0000_0006);
      wr(`DIV_OFS, 32'h0000_0005);
      @(posedge SYS_CLK);
      RST_B <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      #1;
      chk("pins", pexp(4'h1, 3'h0), pins());
      chk("irq", 32'h0000_0000, {31'h0000_0000, IRQ});
      report_and_stop();
   end
endmodule
